// File: design/ledfs_pkg.sv
// Shared constants, register map and types of the LED driver fault sequencer
package ledfs_pkg;
  // Clock and timer base
  localparam int CLK_HZ = 250_000_000;
  localparam int TIMER_HZ = 1_000_000;
  localparam int TICK_DIV = CLK_HZ / TIMER_HZ;
  localparam int TICK_W = 8;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
  localparam logic [TICK_W-1:0] TICK_ZERO = 8'h00;
  // Timer lengths in their own units, then in timer ticks
  localparam int TMR_W = 20;
  localparam int HOLDOFF_MS = 1;
  localparam int DIM_OFF_MS = 50;
  localparam int FAULT_MS = 50;
  localparam int TICKS_PER_MS = TIMER_HZ / 1000;
  localparam logic [TMR_W-1:0] HOLDOFF_TICKS = TMR_W'(HOLDOFF_MS * TICKS_PER_MS);
  localparam logic [TMR_W-1:0] DIM_OFF_TICKS = TMR_W'(DIM_OFF_MS * TICKS_PER_MS);
  localparam logic [TMR_W-1:0] FAULT_TICKS = TMR_W'(FAULT_MS * TICKS_PER_MS);
  localparam logic [TMR_W-1:0] TMR_ZERO = 20'h00000;
  localparam logic [TMR_W-1:0] TMR_ONE = 20'h00001;
  // Feedback target arithmetic, in millivolts
  localparam int MV_W = 12;
  localparam logic [MV_W-1:0] FIXED_REF_MV = 12'h190;
  localparam logic [MV_W-1:0] LEVEL_DIVISOR = 12'h005;
  localparam logic [MV_W-1:0] DERATE_RST = 12'h064;
  localparam logic [MV_W-1:0] MV_ZERO = 12'h000;
  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h8;
  localparam logic [ADDR_W-1:0] REG_DERATE = 4'hC;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
  // Status and mask layout
  localparam int ST_W = 6;
  localparam int ST_HOLDOFF_DONE = 0;
  localparam int ST_OVP_STOP = 1;
  localparam int ST_THERMAL_STOP = 2;
  localparam int ST_INPUT_OV = 3;
  localparam int ST_FAULT_LATCH = 4;
  localparam int ST_DIM_SHUTDOWN = 5;
  localparam logic [ST_W-1:0] ST_RST = 6'h00;
  localparam int STATE_W = 11;
  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_HOLDOFF = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_SHUTDOWN = 2'b10,
    SEQ_LATCHED = 2'b11
  } ledfs_state_t;
  // Register select, used by both read and write paths
  function automatic logic ledfs_sel(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    ledfs_sel = (addr == off);
  endfunction
endpackage

// File: design/ledfs_timer.sv
// Persistence timer: expires once its input stays active beyond a tick limit
`timescale 1ns/1ns
module ledfs_timer (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Timing
  input wire logic tick_i,
  input wire logic active_i,
  input wire logic [ledfs_pkg::TMR_W-1:0] limit_i,
  // Result
  output logic expired_o
);
  import ledfs_pkg::*;

  logic [TMR_W-1:0] count_r;

  // R17: restart when inactive
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count_r <= TMR_ZERO;
      expired_o <= 1'b0;
    end else if (ce_i) begin
      if (!active_i) begin
        count_r <= TMR_ZERO;
        expired_o <= 1'b0;
      end else if (tick_i && !expired_o) begin
        // Expiry only after the limit is passed, so strictly longer than it
        if (count_r >= limit_i) begin
          expired_o <= 1'b1;
        end else begin
          count_r <= count_r + TMR_ONE;
        end
      end
    end
  end

  property p_restart;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !active_i |=> count_r == TMR_ZERO && !expired_o;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted"); // R17

  property p_expiry_needs_count;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(expired_o) |-> $past(count_r) >= limit_i && $past(active_i);
  endproperty
  a_expiry_needs_count: assert property (p_expiry_needs_count) else $error("early expiry"); // R10
endmodule

// File: design/ledfs_top.sv
// LED driver start-up, dimming, reference and fault sequencer with Avalon-MM registers
`timescale 1ns/1ns
// Notes on behaviour
// R1: Hold off switching 1ms after reset
// R2: Load isolation gate follows dimming enable
// R3: Shut down after 50ms enable inactive
// R4: Reference select high: target is setpoint/5
// R5: Reference select low: fixed 400mV target
// R6: Hot LED lowers target when control enabled
// R7: Feedback above half rail: reference to supply
// R8: Pump protection gate; drop on input overvoltage
// R9: Watch regulation loss, output and input overvoltage
// R10: Fault beyond 50ms opens input protection switch
// R11: Non-input faults latch; enable or supply cycle clears
// R12: Limit setpoint at rail disables latch, derating
// R13: Output overvoltage stop with hysteresis restart
// R14: Die over 135C stops, below 100C resumes
// R15: Strapped topology select adopted by device
// R16: Timers run from 1MHz converter tick
// R17: Fault timer restarts when fault clears
module ledfs_top #(
  parameter logic [ledfs_pkg::TMR_W-1:0] HOLDOFF_TICKS_P = ledfs_pkg::HOLDOFF_TICKS,
  parameter logic [ledfs_pkg::TMR_W-1:0] DIM_OFF_TICKS_P = ledfs_pkg::DIM_OFF_TICKS,
  parameter logic [ledfs_pkg::TMR_W-1:0] FAULT_TICKS_P = ledfs_pkg::FAULT_TICKS
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Avalon-MM slave
  input wire logic [ledfs_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ledfs_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [ledfs_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // Straps and control pins
  input wire logic enable_dimming_i,
  input wire logic ref_select_i,
  input wire logic topology_select_i,
  input wire logic temp_limit_at_rail_i,
  input wire logic input_supply_ok_i,
  // Comparator results and bias setpoint
  input wire logic ovp_above_upper_i,
  input wire logic ovp_below_lower_i,
  input wire logic die_above_135c_i,
  input wire logic die_below_100c_i,
  input wire logic fb_above_half_rail_i,
  input wire logic fb_regulation_lost_i,
  input wire logic input_overvoltage_i,
  input wire logic led_temp_above_limit_i,
  input wire logic [ledfs_pkg::MV_W-1:0] bias_setpoint_mv_i,
  // Power stage controls
  output logic switch_enable_o,
  output logic load_isolation_gate_o,
  output logic input_switch_gate_o,
  output logic fb_ref_to_supply_o,
  output logic buck_mode_o,
  output logic [ledfs_pkg::MV_W-1:0] fb_target_mv_o
);
  import ledfs_pkg::*;

  ledfs_state_t state_r;
  ledfs_state_t state_nxt;
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick_r;
  logic [TMR_W-1:0] hold_cnt_r;
  logic holdoff_done;
  logic strap_taken_r;
  logic ovp_stop_r;
  logic thermal_stop_r;
  logic input_ov_r;
  logic fault_any;
  logic fault_expired;
  logic dim_expired;
  logic latch_go;
  logic derate_on;
  logic [MV_W-1:0] base_mv;
  logic [MV_W-1:0] target_nxt;
  logic [MV_W-1:0] derate_r;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] mask_r;
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] clear_bits;
  logic bus_req;
  logic wr_go;
  logic [STATE_W-1:0] state_view;

  // R16: 1MHz timer tick
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_r <= TICK_ZERO;
      tick_r <= 1'b0;
    end else if (ce_i) begin
      tick_r <= (tick_cnt_r == TICK_LAST);
      tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? TICK_ZERO : tick_cnt_r + 8'h01;
    end
  end
  // R15: strap taken after reset release
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strap_taken_r <= 1'b0;
      buck_mode_o <= 1'b0;
    end else if (ce_i && !strap_taken_r) begin
      strap_taken_r <= 1'b1;
      buck_mode_o <= topology_select_i;
    end
  end
  // R1: start-up hold-off count
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hold_cnt_r <= TMR_ZERO;
    end else if (ce_i) begin
      if (state_r != SEQ_HOLDOFF || !input_supply_ok_i) begin
        hold_cnt_r <= TMR_ZERO;
      end else if (tick_r && !holdoff_done) begin
        hold_cnt_r <= hold_cnt_r + TMR_ONE;
      end
    end
  end
  assign holdoff_done = (hold_cnt_r >= HOLDOFF_TICKS_P);
  // R13: output overvoltage hysteresis
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ovp_stop_r <= 1'b0;
    end else if (ce_i) begin
      if (ovp_above_upper_i) begin
        ovp_stop_r <= 1'b1;
      end else if (ovp_below_lower_i) begin
        ovp_stop_r <= 1'b0;
      end
    end
  end
  // R14: die temperature hysteresis
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      thermal_stop_r <= 1'b0;
      input_ov_r <= 1'b0;
    end else if (ce_i) begin
      input_ov_r <= input_overvoltage_i;
      if (die_above_135c_i) begin
        thermal_stop_r <= 1'b1;
      end else if (die_below_100c_i) begin
        thermal_stop_r <= 1'b0;
      end
    end
  end
  // R9: monitored faults
  assign fault_any = fb_regulation_lost_i | ovp_stop_r | input_overvoltage_i;
  ledfs_timer u_fault_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(tick_r),
    .active_i(fault_any),
    .limit_i(FAULT_TICKS_P),
    .expired_o(fault_expired)
  );
  // R3: enable inactive timer
  ledfs_timer u_dim_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(tick_r),
    .active_i(!enable_dimming_i && state_r == SEQ_RUN),
    .limit_i(DIM_OFF_TICKS_P),
    .expired_o(dim_expired)
  );
  // R11: only non-input faults latch; R12: strap disables the latch
  assign latch_go = fault_expired && (fb_regulation_lost_i || ovp_stop_r) &&
                    !temp_limit_at_rail_i && state_r == SEQ_RUN;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SEQ_HOLDOFF: begin
        if (holdoff_done) begin
          state_nxt = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (latch_go) begin
          state_nxt = SEQ_LATCHED;
        end else if (dim_expired) begin
          state_nxt = SEQ_SHUTDOWN;
        end
      end
      SEQ_SHUTDOWN: begin
        if (enable_dimming_i) begin
          state_nxt = SEQ_RUN;
        end
      end
      SEQ_LATCHED: begin
        // R11: enable low clears the latch
        if (!enable_dimming_i) begin
          state_nxt = SEQ_SHUTDOWN;
        end
      end
    endcase
    // R11: supply loss clears the latch, restarts hold-off
    if (!input_supply_ok_i) begin
      state_nxt = SEQ_HOLDOFF;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_r <= SEQ_HOLDOFF;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end
  // R4: level mode target
  // R5: fixed reference mode
  assign base_mv = ref_select_i ? bias_setpoint_mv_i / LEVEL_DIVISOR : FIXED_REF_MV;
  // R6: derate a hot LED; R12: not while the limit sits at the rail
  assign derate_on = led_temp_above_limit_i && !temp_limit_at_rail_i;
  assign target_nxt = !derate_on ? base_mv : (base_mv > derate_r) ? base_mv - derate_r : MV_ZERO;
  // Power stage outputs, all registered
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      switch_enable_o <= 1'b0;
      load_isolation_gate_o <= 1'b0;
      input_switch_gate_o <= 1'b1;
      fb_ref_to_supply_o <= 1'b0;
      fb_target_mv_o <= FIXED_REF_MV;
    end else if (ce_i) begin
      // R1: no switching before hold-off; R13 and R14 gate it too
      switch_enable_o <= state_r == SEQ_RUN && enable_dimming_i && strap_taken_r &&
                         !ovp_stop_r && !thermal_stop_r && !input_overvoltage_i &&
                         !fault_expired;
      // R2: disconnect the string during dimming off time
      load_isolation_gate_o <= state_r == SEQ_RUN && enable_dimming_i;
      // R8: pumped unless input overvoltage; R10: opened by expired fault, held open while latched
      input_switch_gate_o <= !(input_overvoltage_i || fault_expired || state_r == SEQ_LATCHED);
      // R7: feedback reference auto switch
      fb_ref_to_supply_o <= fb_above_half_rail_i;
      fb_target_mv_o <= target_nxt;
    end
  end

  // Register bus: one wait cycle, then the access completes
  assign bus_req = avs_read_i || avs_write_i;
  assign wr_go = avs_write_i && !avs_waitrequest_o;
  assign state_view = {buck_mode_o, fb_ref_to_supply_o, input_switch_gate_o,
                       load_isolation_gate_o, switch_enable_o, thermal_stop_r,
                       ovp_stop_r, input_ov_r, fault_expired, state_r};

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= DATA_ZERO;
    end else if (ce_i) begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= DATA_ZERO;
        if (ledfs_sel(avs_address_i, REG_STATUS)) begin
          avs_readdata_o[ST_W-1:0] <= status_r;
        end else if (ledfs_sel(avs_address_i, REG_MASK)) begin
          avs_readdata_o[ST_W-1:0] <= mask_r;
        end else if (ledfs_sel(avs_address_i, REG_STATE)) begin
          avs_readdata_o[STATE_W-1:0] <= state_view;
        end else if (ledfs_sel(avs_address_i, REG_DERATE)) begin
          avs_readdata_o[MV_W-1:0] <= derate_r;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mask_r <= ST_RST;
      derate_r <= DERATE_RST;
    end else if (ce_i && wr_go) begin
      if (ledfs_sel(avs_address_i, REG_MASK) && avs_byteenable_i[0]) begin
        mask_r <= avs_writedata_i[ST_W-1:0];
      end
      if (ledfs_sel(avs_address_i, REG_DERATE)) begin
        if (avs_byteenable_i[0]) begin
          derate_r[7:0] <= avs_writedata_i[7:0];
        end
        if (avs_byteenable_i[1]) begin
          derate_r[MV_W-1:8] <= avs_writedata_i[MV_W-1:8];
        end
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins
  assign events[ST_HOLDOFF_DONE] = state_r == SEQ_HOLDOFF && state_nxt == SEQ_RUN;
  assign events[ST_OVP_STOP] = ovp_above_upper_i && !ovp_stop_r;
  assign events[ST_THERMAL_STOP] = die_above_135c_i && !thermal_stop_r;
  assign events[ST_INPUT_OV] = input_overvoltage_i && !input_ov_r;
  assign events[ST_FAULT_LATCH] = latch_go;
  assign events[ST_DIM_SHUTDOWN] = state_r == SEQ_RUN && state_nxt == SEQ_SHUTDOWN;
  assign clear_bits = (wr_go && ledfs_sel(avs_address_i, REG_STATUS) && avs_byteenable_i[0]) ?
                      avs_writedata_i[ST_W-1:0] : ST_RST;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      status_r <= ST_RST;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      status_r <= (status_r & ~clear_bits) | events;
      irq_o <= |(status_r & mask_r);
    end
  end

  sequence s_ovp_hit;
    ce_i && ovp_above_upper_i ##1 ce_i;
  endsequence
  sequence s_hot_die;
    ce_i && die_above_135c_i ##1 ce_i;
  endsequence
  property p_holdoff;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && state_r == SEQ_HOLDOFF |=> !switch_enable_o;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("switching during hold-off"); // R1
  property p_load_gate;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !enable_dimming_i |=> !load_isolation_gate_o;
  endproperty
  a_load_gate: assert property (p_load_gate) else $error("load gate on while dimmed"); // R2
  property p_dim_shutdown;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && state_r == SEQ_RUN && dim_expired && !latch_go && input_supply_ok_i
    |=> state_r == SEQ_SHUTDOWN;
  endproperty
  a_dim_shutdown: assert property (p_dim_shutdown) else $error("no dimming shutdown"); // R3
  property p_fixed_ref;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !ref_select_i && !derate_on |=> fb_target_mv_o == FIXED_REF_MV;
  endproperty
  a_fixed_ref: assert property (p_fixed_ref) else $error("fixed reference wrong"); // R5
  property p_derate;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && derate_on && base_mv > derate_r |=> fb_target_mv_o < $past(base_mv);
  endproperty
  a_derate: assert property (p_derate) else $error("target not lowered"); // R6
  property p_input_ov_gate;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && input_overvoltage_i |=> !input_switch_gate_o ##0 !switch_enable_o;
  endproperty
  a_input_ov_gate: assert property (p_input_ov_gate) else $error("gate not discharged"); // R8
  property p_fault_gate;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && fault_expired |=> !input_switch_gate_o;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("fault switch not opened"); // R10
  property p_latch_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_r == SEQ_LATCHED && enable_dimming_i && input_supply_ok_i |=> state_r == SEQ_LATCHED;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch left early"); // R11
  property p_ovp_stop;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_ovp_hit |=> !switch_enable_o;
  endproperty
  a_ovp_stop: assert property (p_ovp_stop) else $error("switching above upper limit"); // R13
  property p_thermal_stop;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_hot_die |=> !switch_enable_o;
  endproperty
  a_thermal_stop: assert property (p_thermal_stop) else $error("switching while die hot"); // R14
endmodule

// File: verification/ledfs_power_stage.sv
// Behavioural model of the power stage, LED string and sensors beside the sequencer
`timescale 1ns/1ns
module ledfs_power_stage #(
  parameter int OVH_MV = 30000,
  parameter int OVL_MV = 27000,
  parameter int RAIL_MV = 5000
) (
  // Analog levels, in mV or degrees C
  input wire logic [15:0] vout_mv_i,
  input wire logic [15:0] die_c_i,
  input wire logic [15:0] fb_mv_i,
  input wire logic [15:0] led_mv_i,
  input wire logic [15:0] temp_limit_setpoint_mv_i,
  // Comparator results
  output logic ovp_above_upper_o,
  output logic ovp_below_lower_o,
  output logic die_above_135c_o,
  output logic die_below_100c_o,
  output logic fb_above_half_rail_o,
  output logic led_temp_above_limit_o,
  output logic temp_limit_at_rail_o
);
  assign ovp_above_upper_o = (int'(vout_mv_i) > OVH_MV);
  assign ovp_below_lower_o = (int'(vout_mv_i) < OVL_MV);
  assign die_above_135c_o = (die_c_i > 16'h0087);
  assign die_below_100c_o = (die_c_i < 16'h0064);
  // half rail sense, equal is not above
  assign fb_above_half_rail_o = (int'(fb_mv_i) > RAIL_MV / 2);
  assign led_temp_above_limit_o = (led_mv_i > temp_limit_setpoint_mv_i);
  assign temp_limit_at_rail_o = (int'(temp_limit_setpoint_mv_i) >= RAIL_MV);
endmodule

// File: verification/ledfs_top_bench.sv
// Self-checking bench for the LED driver fault sequencer
`timescale 1ns/1ns
module ledfs_top_bench;
  import ledfs_pkg::*;
  // Short timers keep the run brief; the hold-off and dimming waits derive from them
  localparam logic [TMR_W-1:0] HO = 20'h00004;
  localparam logic [TMR_W-1:0] DO = 20'h00008;
  localparam logic [TMR_W-1:0] FT = 20'h00008;
  localparam int TK = TICK_DIV;
  logic clk, rst_n, rd, wr, en, refs, topo, supok, fblost, inov, ce;
  logic [3:0] addr, be;
  logic [31:0] wd, rdata, q;
  logic [11:0] bias, tgt;
  logic [15:0] vout, diec, fbmv, ledmv, tmaxmv;
  logic wreq, irq, swen, lgate, igate, fbref, buck;
  logic ova, ovb, dha, dlb, fbh, hot, atrail;
  int fails, checks_done;

  ledfs_top #(.HOLDOFF_TICKS_P(HO), .DIM_OFF_TICKS_P(DO), .FAULT_TICKS_P(FT)) dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .irq_o(irq),
    .enable_dimming_i(en), .ref_select_i(refs), .topology_select_i(topo),
    .temp_limit_at_rail_i(atrail), .input_supply_ok_i(supok),
    .ovp_above_upper_i(ova), .ovp_below_lower_i(ovb), .die_above_135c_i(dha),
    .die_below_100c_i(dlb), .fb_above_half_rail_i(fbh), .fb_regulation_lost_i(fblost),
    .input_overvoltage_i(inov), .led_temp_above_limit_i(hot), .bias_setpoint_mv_i(bias),
    .switch_enable_o(swen), .load_isolation_gate_o(lgate), .input_switch_gate_o(igate),
    .fb_ref_to_supply_o(fbref), .buck_mode_o(buck), .fb_target_mv_o(tgt)
  );
  ledfs_power_stage ps (
    .vout_mv_i(vout), .die_c_i(diec), .fb_mv_i(fbmv), .led_mv_i(ledmv), .temp_limit_setpoint_mv_i(tmaxmv),
    .ovp_above_upper_o(ova), .ovp_below_lower_o(ovb), .die_above_135c_o(dha),
    .die_below_100c_o(dlb), .fb_above_half_rail_o(fbh), .led_temp_above_limit_o(hot),
    .temp_limit_at_rail_o(atrail)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Holds the request until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata;
    if (n >= 20) chk("bus answer", 32'h1, 32'h0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    wt(3);
    rst_n <= 1'b1;
  endtask

  task automatic t_start();
    chk("gate at reset", 1, igate);
    chk("target at reset", FIXED_REF_MV, tgt);
    wt((HO - 1) * TK - 5);
    chk("held off", 0, swen);
    wt(4 * TK);
    chk("switching", 1, swen);
    chk("buck strap", 1, buck);
  endtask

  task automatic t_regs();
    bus(1'b0, REG_STATUS, DATA_ZERO);
    chk("status", 32'h1, q);
    bus(1'b1, REG_MASK, 32'h1);
    bus(1'b0, REG_MASK, DATA_ZERO);
    chk("mask", 32'h1, q);
    wt(3);
    chk("irq set", 1, irq);
    bus(1'b1, REG_STATUS, 32'h1);
    wt(3);
    chk("irq clear", 0, irq);
    bus(1'b0, 4'h2, DATA_ZERO);
    chk("unmapped", 0, q);
    bus(1'b0, REG_DERATE, DATA_ZERO);
    chk("derate", 32'(DERATE_RST), q);
    bus(1'b0, REG_STATE, DATA_ZERO);
    chk("state", 32'h5C1, q);
  endtask

  task automatic t_ref();
    refs <= 1'b1;
    bias <= 12'h3E8;
    wt(4);
    chk("level target", 12'h0C8, tgt);
    refs <= 1'b0;
    wt(4);
    chk("fixed target", FIXED_REF_MV, tgt);
    ledmv <= 16'h0BB8;
    wt(4);
    chk("hot fixed", FIXED_REF_MV - DERATE_RST, tgt);
    refs <= 1'b1;
    wt(4);
    chk("hot level", 12'h0C8 - DERATE_RST, tgt);
    tmaxmv <= 16'h1388;
    ledmv <= 16'h1770;
    wt(4);
    chk("derate off", 12'h0C8, tgt);
    fbmv <= 16'h09C4;
    wt(4);
    chk("half rail", 0, fbref);
    fbmv <= 16'h0A28;
    wt(4);
    chk("above half", 1, fbref);
  endtask

  task automatic t_dim();
    en <= 1'b0;
    wt(3);
    chk("load gate off", 0, lgate);
    wt((DO - 1) * TK);
    en <= 1'b1;
    wt(3);
    chk("load gate on", 1, lgate);
    chk("short off", 1, swen);
    en <= 1'b0;
    wt((DO + 3) * TK);
    bus(1'b0, REG_STATE, DATA_ZERO);
    chk("shutdown", 2'b10, q[1:0]);
    en <= 1'b1;
    wt(6);
    chk("resume", 1, swen);
  endtask

  task automatic t_stop();
    vout <= 16'h7918;
    wt(3);
    chk("ovp stop", 0, swen);
    vout <= 16'h6D60;
    wt(20);
    chk("ovp band", 0, swen);
    vout <= 16'h3A98;
    wt(4);
    chk("ovp resume", 1, swen);
    diec <= 16'h008C;
    wt(3);
    chk("hot die", 0, swen);
    diec <= 16'h0078;
    wt(20);
    chk("die band", 0, swen);
    diec <= 16'h005A;
    wt(4);
    chk("die resume", 1, swen);
  endtask

  // Clock enable low must freeze the registered outputs
  task automatic t_freeze();
    ce <= 1'b0;
    en <= 1'b0;
    wt(5);
    chk("frozen gate", 1, lgate);
    ce <= 1'b1;
    wt(3);
    chk("thawed gate", 0, lgate);
    en <= 1'b1;
    wt(3);
    chk("gate back", 1, lgate);
  endtask

  task automatic t_fault();
    fblost <= 1'b1;
    wt(5 * TK);
    fblost <= 1'b0;
    wt(10);
    fblost <= 1'b1;
    wt(6 * TK);
    chk("timer restart", 1, igate);
    wt(5 * TK);
    chk("gate opened", 0, igate);
    chk("no switching", 0, swen);
    fblost <= 1'b0;
    wt(TK);
    bus(1'b0, REG_STATE, DATA_ZERO);
    chk("latched", 2'b11, q[1:0]);
    en <= 1'b0;
    wt(5);
    en <= 1'b1;
    wt(6);
    chk("latch cleared", 1, swen);
    tmaxmv <= 16'h1388;
    fblost <= 1'b1;
    wt(11 * TK);
    chk("gate opened", 0, igate);
    fblost <= 1'b0;
    wt(TK);
    bus(1'b0, REG_STATE, DATA_ZERO);
    chk("no latch", 2'b01, q[1:0]);
    inov <= 1'b1;
    wt(2);
    chk("gate dropped", 0, igate);
    inov <= 1'b0;
    wt(4);
    chk("gate pumped", 1, igate);
  endtask

  task automatic t_strap();
    topo <= 1'b0;
    do_reset();
    wt(3);
    chk("boost strap", 0, buck);
  endtask

  initial begin
    wt(60000);
    fails++;
    conclude();
  end

  initial begin
    fails = 0;
    checks_done = 0;
    {rst_n, rd, wr, fblost, inov, refs} = 6'h00;
    {en, topo, supok, ce} = 4'b1111;
    addr = 4'h0;
    be = 4'hF;
    wd = 32'h00000000;
    bias = 12'h000;
    vout = 16'h3A98;
    diec = 16'h0019;
    fbmv = 16'h0000;
    ledmv = 16'h0000;
    tmaxmv = 16'h03E8;
    do_reset();
    t_start();
    t_regs();
    t_ref();
    tmaxmv <= 16'h03E8;
    ledmv <= 16'h0000;
    t_dim();
    t_stop();
    t_freeze();
    t_fault();
    t_strap();
    conclude();
  end
endmodule
